// ### angle_cfg_pkg.sv
// Shared constants for the angle sensor digital core.
package angle_cfg_pkg;

  // ==========================================================================
  // Widths
  localparam int ANGLE_W = 16;
  localparam int REG_W   = 8;
  localparam int FRAME_W = 16;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS    = 10;
  localparam int SAMPLE_TIME_NS   = 2000;
  localparam int SAMPLE_CYCLES    = (SAMPLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAMPLE_CNT_W     = $clog2(SAMPLE_CYCLES + 1);
  localparam int SPEED_WINDOW     = 256;
  localparam int SPEED_SHIFT      = $clog2(SPEED_WINDOW);

  // ==========================================================================
  // Serial commands and register addresses
  localparam logic [3:0] CMD_READ   = 4'h1;
  localparam logic [3:0] CMD_WRITE  = 4'h2;
  localparam logic [3:0] ADDR_TRIM  = 4'h3;
  localparam logic [3:0] ADDR_ZERO  = 4'h4;
  localparam logic [3:0] ADDR_AXIS  = 4'h5;
  localparam logic [3:0] ADDR_BURN  = 4'h9;

  // Burn control bit positions and axis enable positions.
  localparam int BURN_TRIM_BIT  = 3;
  localparam int BURN_ZERO_BIT  = 4;
  localparam int BURN_AXIS_BIT  = 5;
  localparam int X_TRIM_BIT     = 4;
  localparam int Y_TRIM_BIT     = 5;

  // Index of each programmable register in the three-entry arrays.
  localparam int IDX_TRIM = 0;
  localparam int IDX_ZERO = 1;
  localparam int IDX_AXIS = 2;

  localparam logic [REG_W-1:0]   REG_RESET  = 8'h00;
  localparam logic [REG_W-1:0]   AXIS_MASK  = 8'h30;
  localparam logic [ANGLE_W-1:0] ANGLE_ZERO = 16'h0000;

  // Commutation thresholds: 60, 120, 180, 240 and 300 degrees of one turn.
  localparam logic [ANGLE_W-1:0] TH_60  = 16'h2AAB;
  localparam logic [ANGLE_W-1:0] TH_120 = 16'h5555;
  localparam logic [ANGLE_W-1:0] TH_180 = 16'h8000;
  localparam logic [ANGLE_W-1:0] TH_240 = 16'hAAAB;
  localparam logic [ANGLE_W-1:0] TH_300 = 16'hD555;

  typedef enum logic [1:0] {
    LOAD_WAIT = 2'b00,
    LOAD_RUN  = 2'b01
  } load_state_t;

endpackage : angle_cfg_pkg

// ### angle_est_if.sv
// Carrier between the serial core and the angle estimator.
interface angle_est_if;
  import angle_cfg_pkg::*;
  logic               sample_valid;
  logic [ANGLE_W-1:0] sample_angle;
  logic [ANGLE_W-1:0] est_angle;

  modport src (output sample_valid, output sample_angle, input est_angle);
  modport est (input sample_valid, input sample_angle, output est_angle);
endinterface : angle_est_if

// ### angle_estimator.sv
// Speed-aided angle estimator fed by raw front-end samples.
module angle_estimator
  import angle_cfg_pkg::*;
(
  input  wire logic   clk_i,   // System clock.
  input  wire logic   rst_n_i, // Asynchronous reset, active low.
  angle_est_if.est    ang      // Samples in, estimate out.
);
  import angle_cfg_pkg::*;

  logic [SPEED_SHIFT-1:0] win_cnt_q;
  logic [ANGLE_W-1:0]     win_start_q;
  logic [ANGLE_W-1:0]     delta_q;
  logic [ANGLE_W-1:0]     est_q;
  logic [ANGLE_W-1:0]     step_d;

  // ==========================================================================
  // Speed over the latest window of samples
  // Wrap-around subtraction keeps the delta signed modulo one turn.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      win_cnt_q   <= '0;
      win_start_q <= ANGLE_ZERO;
      delta_q     <= ANGLE_ZERO;
    end else if (ang.sample_valid) begin
      win_cnt_q <= win_cnt_q + 1'b1;
      if (win_cnt_q == '1) begin
        delta_q     <= ang.sample_angle - win_start_q;
        win_start_q <= ang.sample_angle;
      end
    end
  end

  // Per-sample step is the window delta divided by the window length.
  assign step_d = ANGLE_W'($signed(delta_q) >>> SPEED_SHIFT);

  // ==========================================================================
  // Prediction
  // One step ahead compensates the sample age, so no extra lag is added.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      est_q <= ANGLE_ZERO;
    end else if (ang.sample_valid) begin
      est_q <= ang.sample_angle + step_d;
    end
  end

  assign ang.est_angle = est_q;

endmodule // angle_estimator

// ### angle_sensor_core.sv
// Serial configuration, zero offset, output buffer and commutation core.

module angle_sensor_core
  import angle_cfg_pkg::*;
(
  input  wire logic                       sys_clk_i,                 // System clock, 100 MHz.
  input  wire logic                       rst_n_i,                   // Async reset, active low.
  input  wire logic [angle_cfg_pkg::ANGLE_W-1:0] fe_angle_i,         // Raw front-end angle.
  input  wire logic                       fe_valid_i,                // Front-end sample strobe.
  input  wire logic                       cs_n_i,                    // Serial chip select pin.
  input  wire logic                       sclk_i,                    // Serial clock pin.
  input  wire logic                       mosi_i,                    // Serial data in pin.
  output logic                            miso_o,                    // Serial data out pin.
  input  wire logic                       fuse_programming_supply_i, // Fuse supply present.
  input  wire logic [2:0]                 fuse_burned_i,             // Fuse burned flags.
  input  wire logic [3*angle_cfg_pkg::REG_W-1:0] fuse_data_i,        // Fuse contents.
  output logic [2:0]                      fuse_burn_o,               // Burn strobe per register.
  output logic [angle_cfg_pkg::REG_W-1:0] fuse_burn_data_o,          // Value being burned.
  output logic [angle_cfg_pkg::REG_W-1:0] bias_trim_amount_o,        // Bias trim to front end.
  output logic                            x_axis_trim_enable_o,      // X-axis trim enable.
  output logic                            y_axis_trim_enable_o,      // Y-axis trim enable.
  output logic [2:0]                      commutation_outputs_o      // Hall emulation outputs.
);
  import angle_cfg_pkg::*;

  // ==========================================================================
  // Pin synchronisers
  // Stage one is only read by stage two; edges come from stages two and three.
  logic [2:0] cs_sync_q;
  logic [2:0] sclk_sync_q;
  logic [1:0] mosi_sync_q;
  logic [1:0] supply_sync_q;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_sync_q     <= 3'h7;
      sclk_sync_q   <= 3'h0;
      mosi_sync_q   <= 2'h0;
      supply_sync_q <= 2'h0;
    end else begin
      cs_sync_q     <= {cs_sync_q[1:0], cs_n_i};
      sclk_sync_q   <= {sclk_sync_q[1:0], sclk_i};
      mosi_sync_q   <= {mosi_sync_q[0], mosi_i};
      supply_sync_q <= {supply_sync_q[0], fuse_programming_supply_i};
    end
  end

  logic cs_low;
  logic cs_fall;
  logic sclk_rise;
  logic sclk_fall;
  logic mosi_s;
  logic supply_ok;

  assign cs_low    = !cs_sync_q[1];
  assign cs_fall   = cs_sync_q[2] && !cs_sync_q[1];
  assign sclk_rise = !sclk_sync_q[2] && sclk_sync_q[1];
  assign sclk_fall = sclk_sync_q[2] && !sclk_sync_q[1];
  assign mosi_s    = mosi_sync_q[1];
  assign supply_ok = supply_sync_q[1];

  // ==========================================================================
  // Angle estimator
  angle_est_if ang_if ();

  assign ang_if.sample_valid = fe_valid_i;
  assign ang_if.sample_angle = fe_angle_i;

  angle_estimator u_est (
    .clk_i   (sys_clk_i),
    .rst_n_i (rst_n_i),
    .ang     (ang_if.est)
  );

  // ==========================================================================
  // Programmable registers and fuse start-up load
  logic [REG_W-1:0] cfg_q [3];
  logic [2:0]       locked_q;
  load_state_t      load_q;

  logic [FRAME_W-1:0] rx_q;
  logic [4:0]         bit_cnt_q;
  logic               frame_done;
  logic [FRAME_W-1:0] frame_word;
  logic [3:0]         f_cmd;
  logic [3:0]         f_addr;
  logic [REG_W-1:0]   f_val;
  logic               wr_hit;
  logic [1:0]         wr_idx;
  logic               wr_ok;
  logic [2:0]         burn_req;
  logic               burn_go;

  assign frame_done = cs_low && sclk_rise && (bit_cnt_q == 5'(FRAME_W - 1));
  assign frame_word = {rx_q[FRAME_W-2:0], mosi_s};
  assign f_cmd      = frame_word[15:12];
  assign f_addr     = frame_word[11:8];
  assign f_val      = frame_word[7:0];

  always_comb begin
    wr_hit = 1'b1;
    wr_idx = 2'(IDX_TRIM);
    case (f_addr)
      ADDR_TRIM: wr_idx = 2'(IDX_TRIM);
      ADDR_ZERO: wr_idx = 2'(IDX_ZERO);
      ADDR_AXIS: wr_idx = 2'(IDX_AXIS);
      default:   wr_hit = 1'b0;
    endcase
  end

  // Burned registers are frozen; writes elsewhere or other commands fall away.
  assign wr_ok = frame_done && (f_cmd == CMD_WRITE) && wr_hit && !locked_q[wr_idx];

  // Only a single burn bit per command is honoured, and only with fuse supply.
  assign burn_req = {f_val[BURN_AXIS_BIT], f_val[BURN_ZERO_BIT], f_val[BURN_TRIM_BIT]};
  assign burn_go  = frame_done && (f_cmd == CMD_WRITE) && (f_addr == ADDR_BURN)
                    && $onehot(burn_req) && supply_ok;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      load_q   <= LOAD_WAIT;
      locked_q <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        cfg_q[i] <= REG_RESET;
      end
    end else begin
      case (load_q)
        LOAD_WAIT: begin
          // Fuse contents are caught on the first edge after reset release.
          load_q   <= LOAD_RUN;
          locked_q <= fuse_burned_i;
          for (int i = 0; i < 3; i++) begin
            if (fuse_burned_i[i]) begin
              cfg_q[i] <= fuse_data_i[i*REG_W +: REG_W];
            end
          end
        end
        LOAD_RUN: begin
          if (wr_ok) begin
            if (wr_idx == 2'(IDX_AXIS)) begin
              cfg_q[wr_idx] <= f_val & AXIS_MASK;
            end else begin
              cfg_q[wr_idx] <= f_val;
            end
          end
          if (burn_go) begin
            locked_q <= locked_q | burn_req;
          end
        end
        default: load_q <= LOAD_WAIT;
      endcase
    end
  end

  // ==========================================================================
  // Fuse burn strobes
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fuse_burn_o      <= 3'h0;
      fuse_burn_data_o <= REG_RESET;
    end else begin
      fuse_burn_o <= burn_go ? burn_req : 3'h0;
      if (burn_go) begin
        fuse_burn_data_o <= burn_req[IDX_TRIM] ? cfg_q[IDX_TRIM] :
                            burn_req[IDX_ZERO] ? cfg_q[IDX_ZERO] : cfg_q[IDX_AXIS];
      end
    end
  end

  // ==========================================================================
  // Offset angle
  // The offset is subtracted at use, so a new value acts on the next byte.
  logic [ANGLE_W-1:0] offset_full;
  logic [ANGLE_W-1:0] live_angle;

  assign offset_full = {cfg_q[IDX_ZERO], (ANGLE_W - REG_W)'(0)};
  assign live_angle  = ang_if.est_angle - offset_full;

  // ==========================================================================
  // Output buffer refresh
  logic [SAMPLE_CNT_W-1:0] tick_q;
  logic [ANGLE_W-1:0]      buf_q;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_q <= '0;
      buf_q  <= ANGLE_ZERO;
    end else if (!cs_low) begin
      if (tick_q == SAMPLE_CNT_W'(SAMPLE_CYCLES - 1)) begin
        tick_q <= '0;
        buf_q  <= ang_if.est_angle;
      end else begin
        tick_q <= tick_q + 1'b1;
      end
    end
    // With select low neither counter nor buffer moves.
  end

  logic [REG_W-1:0] angle_byte;
  assign angle_byte = 8'((buf_q - offset_full) >> (ANGLE_W - REG_W));

  // ==========================================================================
  // Serial receive
  // No watchdog: a frame may stall for any time while select stays low.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_q      <= '0;
      bit_cnt_q <= '0;
    end else if (!cs_low) begin
      bit_cnt_q <= '0;
    end else if (sclk_rise) begin
      rx_q <= frame_word;
      if (bit_cnt_q != 5'(FRAME_W)) begin
        bit_cnt_q <= bit_cnt_q + 1'b1;
      end
    end
  end

  // ==========================================================================
  // Read-back data
  logic [REG_W-1:0] rd_data;
  logic             rd_frame;

  always_comb begin
    case (rx_q[3:0])
      ADDR_TRIM: rd_data = cfg_q[IDX_TRIM];
      ADDR_ZERO: rd_data = cfg_q[IDX_ZERO];
      ADDR_AXIS: rd_data = cfg_q[IDX_AXIS];
      default:   rd_data = REG_RESET;
    endcase
  end

  // After eight bits rx_q[7:0] holds command and address of this frame.
  assign rd_frame = (rx_q[7:4] == CMD_READ) && (bit_cnt_q == 5'(REG_W));

  // ==========================================================================
  // Serial transmit
  // Data changes on falling clock, so the master samples on the rising edge.
  logic [REG_W-1:0] tx_q;
  logic [2:0]       tx_bits_q;
  logic             tail_q;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_q      <= REG_RESET;
      tx_bits_q <= 3'h0;
      tail_q    <= 1'b0;
    end else if (cs_fall) begin
      tx_q      <= angle_byte;
      tx_bits_q <= 3'h0;
      tail_q    <= 1'b0;
    end else if (cs_low && sclk_fall) begin
      tx_bits_q <= tx_bits_q + 1'b1;
      if (tx_bits_q == 3'(REG_W - 1)) begin
        // Byte boundary: register byte after a read header, else an angle.
        if (rd_frame && !tail_q) begin
          tx_q <= rd_data;
        end else begin
          tx_q <= angle_byte;
        end
        tail_q <= 1'b1;
      end else begin
        tx_q <= {tx_q[REG_W-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      miso_o <= 1'b0;
    end else if (cs_fall) begin
      miso_o <= angle_byte[REG_W-1];
    end else if (cs_low && sclk_fall) begin
      if (tx_bits_q == 3'(REG_W - 1)) begin
        miso_o <= (rd_frame && !tail_q) ? rd_data[REG_W-1] : angle_byte[REG_W-1];
      end else begin
        miso_o <= tx_q[REG_W-2];
      end
    end
  end

  // ==========================================================================
  // Commutation outputs
  // Three half-turn windows staggered by one sixth of a turn each.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      commutation_outputs_o <= 3'h0;
    end else begin
      commutation_outputs_o[0] <= live_angle < TH_180;
      commutation_outputs_o[1] <= (live_angle >= TH_60) && (live_angle < TH_240);
      commutation_outputs_o[2] <= (live_angle >= TH_120) && (live_angle < TH_300);
    end
  end

  // ==========================================================================
  // Trim outputs to the front end
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bias_trim_amount_o   <= REG_RESET;
      x_axis_trim_enable_o <= 1'b0;
      y_axis_trim_enable_o <= 1'b0;
    end else begin
      bias_trim_amount_o   <= cfg_q[IDX_TRIM];
      x_axis_trim_enable_o <= cfg_q[IDX_AXIS][X_TRIM_BIT];
      y_axis_trim_enable_o <= cfg_q[IDX_AXIS][Y_TRIM_BIT];
    end
  end

endmodule // angle_sensor_core

// ### angle_sensor_core_props.sv
// Concurrent checks on the ports of the angle sensor core.
module angle_sensor_core_props
  import angle_cfg_pkg::*;
(
  input wire logic                              sys_clk_i,                 // System clock.
  input wire logic                              rst_n_i,                   // Reset, active low.
  input wire logic                              cs_n_i,                    // Chip select pin.
  input wire logic                              sclk_i,                    // Serial clock pin.
  input wire logic                              miso_o,                    // Serial data out.
  input wire logic                              fuse_programming_supply_i, // Fuse supply.
  input wire logic [2:0]                        fuse_burn_o,               // Burn strobes.
  input wire logic [angle_cfg_pkg::REG_W-1:0]   fuse_burn_data_o,          // Burned value.
  input wire logic [angle_cfg_pkg::REG_W-1:0]   bias_trim_amount_o,        // Bias trim.
  input wire logic                              x_axis_trim_enable_o,      // X trim enable.
  input wire logic                              y_axis_trim_enable_o,      // Y trim enable.
  input wire logic [2:0]                        commutation_outputs_o      // Hall outputs.
);
  logic [2:0] edge_age_q;

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // ====================================================================
  // Edge age
  // Saturates at seven so that a long idle select never wraps into the legal window.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      edge_age_q <= 3'h7;
    end else if ($fell(sclk_i) || $changed(cs_n_i)) begin
      edge_age_q <= 3'h0;
    end else if (edge_age_q != 3'h7) begin
      edge_age_q <= edge_age_q + 3'h1;
    end
  end

  // ====================================================================
  // Properties
  a_reset_values: assert property (
    $rose(rst_n_i) |-> bias_trim_amount_o == 8'h00 && fuse_burn_o == 3'h0)
    else $error("outputs not clear at reset release");
  a_miso_after_edge: assert property (
    $changed(miso_o) |-> edge_age_q inside {[3'h1:3'h6]})
    else $error("serial output moved without a clock or select edge");
  a_burn_one_hot: assert property (
    fuse_burn_o != 3'h0 |-> $onehot(fuse_burn_o))
    else $error("more than one register burned at once");
  a_burn_single: assert property (
    fuse_burn_o != 3'h0 |=> fuse_burn_o == 3'h0)
    else $error("burn strobe longer than one cycle");
  a_burn_data_held: assert property (
    fuse_burn_o != 3'h0 |=> $stable(fuse_burn_data_o) [*4])
    else $error("burn value not held");
  a_burn_gated: assert property (
    fuse_burn_o != 3'h0 |-> !cs_n_i && $past(fuse_programming_supply_i, 3))
    else $error("burn outside a frame or without supply");
  a_trim_in_frame: assert property (
    $changed(bias_trim_amount_o) |-> !cs_n_i || !$past(rst_n_i, 3))
    else $error("trim changed outside a frame");
  a_axis_in_frame: assert property (
    $changed({x_axis_trim_enable_o, y_axis_trim_enable_o}) |-> !cs_n_i || !$past(rst_n_i, 3))
    else $error("axis enables changed outside a frame");
  a_comm_code: assert property (
    commutation_outputs_o != 3'h2 && commutation_outputs_o != 3'h5)
    else $error("illegal commutation code");
endmodule  // angle_sensor_core_props

// ### spi_master_model.sv
// Behavioural serial master that sends frames into the sensor core.
module spi_master_model (
  output logic      cs_n_o, // Chip select, active low.
  output logic      sclk_o, // Serial clock, idle low.
  output logic      mosi_o, // Data toward the core.
  input  wire logic miso_i  // Data from the core.
);
  timeunit 1ns;
  timeprecision 100ps;
  real half_ns = 62.5;

  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
  end

  // ====================================================================
  // Frame
  // The clock stands still between frames; the data line shows the inverse when released.
  task automatic xfer(input logic [23:0] tx, input int nbits, output logic [23:0] rx);
    rx = 24'h000000;
    cs_n_o = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      mosi_o = tx[23-i];
      #(half_ns);
      sclk_o = 1'b1;
      rx = {rx[22:0], miso_i};
      #(half_ns);
      sclk_o = 1'b0;
    end
    #(half_ns);
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #200;
  endtask
endmodule  // spi_master_model

// ### test_angle_sensor_core.sv
// Self-checking bench for the angle sensor core.
module test_angle_sensor_core;
  timeunit 1ns;
  timeprecision 100ps;
  import angle_cfg_pkg::*;

  logic               sys_clk = 1'b0;
  logic               rst_n = 1'b0;
  logic [ANGLE_W-1:0] fe_angle = 16'h0000;
  logic               fe_valid = 1'b0;
  logic               supply = 1'b0;
  logic [2:0]         fuse_burned = 3'b000;
  logic [23:0]        fuse_data = 24'h000000;
  logic               cs_n, sclk, mosi, miso, x_en, y_en;
  logic [2:0]         burn, comm, last_burn;
  logic [7:0]         burn_data, trim, last_data;
  logic [7:0]         burns = 8'h00;
  logic [23:0]        rx;
  logic [7:0]         exp_burn [3] = '{8'h5A, 8'h24, 8'h30};
  int                 mismatches = 0;
  int                 checked = 0;

  always #5 sys_clk = ~sys_clk;

  angle_sensor_core dut (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .fe_angle_i(fe_angle), .fe_valid_i(fe_valid),
    .cs_n_i(cs_n), .sclk_i(sclk), .mosi_i(mosi), .miso_o(miso),
    .fuse_programming_supply_i(supply), .fuse_burned_i(fuse_burned), .fuse_data_i(fuse_data),
    .fuse_burn_o(burn), .fuse_burn_data_o(burn_data), .bias_trim_amount_o(trim),
    .x_axis_trim_enable_o(x_en), .y_axis_trim_enable_o(y_en), .commutation_outputs_o(comm));

  spi_master_model pm (.cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(mosi), .miso_i(miso));

  always @(posedge sys_clk) begin
    if (burn !== 3'b000) begin
      burns <= burns + 8'h01;
      last_burn <= burn;
      last_data <= burn_data;
    end
  end

  // ====================================================================
  // Tasks
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] c, input logic [3:0] a, input logic [7:0] v);
    pm.xfer({c, a, v, 8'h00}, 16, rx);
  endtask

  task automatic rd(input logic [3:0] a);
    pm.xfer({CMD_READ, a, 16'h0000}, 24, rx);
  endtask

  // Stepping the sample by d for 300 strobes closes at least one speed window; that window can start in the previous feed.
  task automatic feed(input logic [15:0] a0, input logic [15:0] d, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk);
      fe_angle = a0 + d * i[15:0];
      fe_valid = 1'b1;
    end
    @(negedge sys_clk);
    fe_valid = 1'b0;
    repeat (250) @(negedge sys_clk);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ====================================================================
  // Tests
  initial begin
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (10) @(negedge sys_clk);
    check("trim", 8'h00, trim);
    check("axis", 8'h00, {6'h00, y_en, x_en});
    $display("test reset done");
    feed(16'h1000, 16'h0040, 300);
    pm.xfer(24'h0, 8, rx);
    check("speed aided angle", 8'h5B, rx[7:0]);
    feed(16'h4000, 16'h0000, 300);
    check("commutation", 8'h03, {5'h00, comm});
    wr(CMD_WRITE, ADDR_ZERO, 8'h24);
    pm.xfer(24'h0, 8, rx);
    check("offset angle", 8'h1B, rx[7:0]);
    check("offset commutation", 8'h01, {5'h00, comm});
    rd(ADDR_ZERO);
    check("read byte0", 8'h1B, rx[23:16]);
    check("read byte1", 8'h24, rx[15:8]);
    check("read byte2", 8'h1B, rx[7:0]);
    $display("test offset done");
    fork
      pm.xfer(24'h0, 24, rx);
      begin
        #500;
        feed(16'h8000, 16'h0000, 300);
      end
    join
    check("frozen byte0", 8'h1B, rx[23:16]);
    check("frozen byte2", 8'h1B, rx[7:0]);
    pm.xfer(24'h0, 8, rx);
    check("refreshed angle", 8'h5C, rx[7:0]);
    check("commutation", 8'h07, {5'h00, comm});
    $display("test freeze done");
    wr(CMD_WRITE, ADDR_TRIM, 8'h5A);
    wr(CMD_WRITE, ADDR_AXIS, 8'hFF);
    check("trim", 8'h5A, trim);
    check("axis", 8'h03, {6'h00, y_en, x_en});
    rd(ADDR_AXIS);
    check("axis read", 8'h30, rx[15:8]);
    wr(4'h3, ADDR_ZERO, 8'h99);
    wr(CMD_WRITE, 4'h6, 8'h99);
    rd(ADDR_ZERO);
    check("offset kept", 8'h24, rx[15:8]);
    for (int a = 0; a < 16; a++) begin
      if (!(a inside {3, 4, 5, 9})) begin
        rd(4'(a));
        check("unmapped read", 8'h00, rx[15:8]);
      end
    end
    $display("test registers done");
    wr(CMD_WRITE, ADDR_BURN, 8'h10);
    @(negedge sys_clk) supply = 1'b1;
    wr(CMD_WRITE, ADDR_BURN, 8'h18);
    check("refused burns", 8'h00, burns);
    for (int i = 0; i < 3; i++) begin
      wr(CMD_WRITE, ADDR_BURN, 8'h08 << i);
      check("burn strobe", 8'h01 << i, {5'h00, last_burn});
      check("burn data", exp_burn[i], last_data);
    end
    check("burn count", 8'h03, burns);
    @(negedge sys_clk) supply = 1'b0;
    wr(CMD_WRITE, ADDR_ZERO, 8'h11);
    rd(ADDR_ZERO);
    check("locked offset", 8'h24, rx[15:8]);
    $display("test burn done");
    fuse_burned = 3'b001;
    fuse_data = 24'h000077;
    rst_n = 1'b0;
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (10) @(negedge sys_clk);
    check("fuse trim", 8'h77, trim);
    wr(CMD_WRITE, ADDR_TRIM, 8'h01);
    check("locked trim", 8'h77, trim);
    rd(ADDR_ZERO);
    check("offset default", 8'h00, rx[15:8]);
    $display("test fuse load done");
    give_verdict();
  end

  initial begin
    #400000;
    mismatches++;
    give_verdict();
  end
endmodule  // test_angle_sensor_core

bind angle_sensor_core angle_sensor_core_props u_props (
  .sys_clk_i, .rst_n_i, .cs_n_i, .sclk_i, .miso_o, .fuse_programming_supply_i,
  .fuse_burn_o, .fuse_burn_data_o, .bias_trim_amount_o, .x_axis_trim_enable_o,
  .y_axis_trim_enable_o, .commutation_outputs_o);
